/* File: dcs_params.svh */
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH
// Contract
// R1: One service request runs one major iteration.
// R2: On selection clear done/start, set active, load.
// R3: Non-final iteration writes back addresses, decremented count.
// R4: Final iteration adjusts addresses, reloads count, sets done.
// R5: Five-bit modulo per side, zero disables.
// R6: Modulo keeps upper address bits, power-of-two wrap.
// R7: Software status: start, active, then clear/done.
// R8: Hardware request shows no status bits while pending.
// R9: Start bit cleared whenever execution begins.
// R10: Done bit marks major completion, both activations.
// R11: Running channel reads live addresses and count.
// R12: Working byte count decrements as bytes move.
// R13: Other fields read from descriptor storage.
// R14: Preemption only under fixed-priority arbitration.
// R15: Round-robin ignores priority, rotates service.
// R16: Preempted channel keeps its active bit.
// R17: Preempted channel resumes after one iteration.
// R18: Hardware requests honoured only when enabled.
// R19: Request handshake invisible to software.
// R20: Minor loop reads source units, writes destination units.
// R21: Major completion flag only with interrupt enable.
// R22: Request-disable clears hardware enable at completion.
// R23: Acknowledge pulses when hardware service is accepted. The code gives none when a channel is taken by preemption.

// ****************************************************************
// Global register byte offsets.
// ****************************************************************
`define DCS_OFS_CTRL       12'h000
`define DCS_OFS_HWRE       12'h004
`define DCS_OFS_IRQF       12'h008
`define DCS_OFS_CH_BASE    12'h100
`define DCS_CH_STRIDE_LG2  5

// ****************************************************************
// Word index of each descriptor field within a channel window.
// ****************************************************************
`define DCS_W_SADDR        3'h0
`define DCS_W_DADDR        3'h1
`define DCS_W_NBYTES       3'h2
`define DCS_W_OFFS         3'h3
`define DCS_W_SLAST        3'h4
`define DCS_W_DLAST        3'h5
`define DCS_W_ITER         3'h6
`define DCS_W_CSR          3'h7

// ****************************************************************
// Bit positions of the control/status word, and of the round-robin bit in the global control register.
// ****************************************************************
`define DCS_B_START        0
`define DCS_B_INTMAJ       1
`define DCS_B_DREQ         3
`define DCS_B_PREEMPT      4
`define DCS_B_ACTIVE       6
`define DCS_B_DONE         7
`define DCS_B_SSIZE        8
`define DCS_B_DSIZE        10
`define DCS_B_SMOD         16
`define DCS_B_DMOD         24
`define DCS_B_CTRL_RR      2
`endif

/* File: dcs_pkg.sv */
package dcs_pkg;
  // Engine sequencing states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_READ,
    ST_WRITE,
    ST_WBACK
  } dcs_state_t;
endpackage

/* File: dcs_channel_sequencer.sv */
`timescale 1ns/100ps
`include "dcs_params.svh"
module dcs_channel_sequencer #(
  parameter int NCH = 4
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [NCH-1:0]   i_dma_req,
  output logic      [NCH-1:0]   o_dma_ack,
  output logic      [NCH-1:0]   o_channel_irq_flags,
  output logic                  o_mem_req,
  output logic                  o_mem_we,
  output logic      [31:0]      o_mem_addr,
  output logic      [1:0]       o_mem_size,
  output logic      [31:0]      o_mem_wdata,
  input  wire logic             i_mem_ack,
  input  wire logic [31:0]      i_mem_rdata
);
  localparam int CW = $clog2(NCH);

  // The channel count must lie between 2 and 8; any other value is refused at elaboration.
  if (NCH < 2 || NCH > 8) begin : g_bad_nch
    $error("NCH must lie between 2 and 8.");
  end

  // ****************************************************************
  // Helper functions.
  // ****************************************************************
  // Unit size code to byte count; code 3 is treated as a word.
  function automatic logic [2:0] size_bytes(input logic [1:0] code);
    unique case (code)
      2'h0: size_bytes = 3'h1;
      2'h1: size_bytes = 3'h2;
      default: size_bytes = 3'h4;
    endcase
  endfunction

  // Address step with optional modulo wrap of the low bits.
  function automatic logic [31:0] mod_next(input logic [31:0] a, input logic [15:0] off,
                                           input logic [4:0] m);
    logic [31:0] sum;
    logic [31:0] msk;
    sum = a + {{16{off[15]}}, off};
    msk = (32'h1 << m) - 32'h1;
    if (m == 5'h0) mod_next = sum;                        // [R5]
    else mod_next = (a & ~msk) | (sum & msk);             // [R6]
  endfunction

  // Picks a channel: highest index under fixed mode, or rotation downward from the last served one.
  function automatic logic [CW:0] arbitrate(input logic [NCH-1:0] p, input logic rr, input logic [CW-1:0] last);
    logic [CW:0] r;
    int          c;
    r = '0;
    for (int k = 0; k < NCH; k++) begin
      if (rr) c = (int'(last) + 2 * NCH - 1 - k) % NCH;  // [R15]
      else c = NCH - 1 - k;
      if (!r[CW] && p[c]) r = {1'b1, CW'(c)};
    end
    arbitrate = r;
  endfunction

  // ****************************************************************
  // Descriptor storage and global registers.
  // ****************************************************************
  logic [31:0]    sa_ff    [NCH];     // Stored source address.
  logic [31:0]    da_ff    [NCH];     // Stored destination address.
  logic [31:0]    nb_ff    [NCH];     // Minor byte count.
  logic [15:0]    soff_ff  [NCH];     // Source offset.
  logic [15:0]    doff_ff  [NCH];     // Destination offset.
  logic [31:0]    slast_ff [NCH];     // Source last-address adjustment.
  logic [31:0]    dlast_ff [NCH];     // Destination last-address adjustment.
  logic [15:0]    citer_ff [NCH];     // Current iteration count.
  logic [15:0]    biter_ff [NCH];     // Beginning iteration count.
  logic [31:0]    csr_ff   [NCH];     // Control/status word.
  logic [NCH-1:0] hwre_ff;            // Hardware request enables.
  logic [NCH-1:0] irqf_ff;            // Channel interrupt request flags.
  logic           rr_ff;              // Round-robin mode when set.

  // ****************************************************************
  // Engine working registers.
  // ****************************************************************
  dcs_pkg::dcs_state_t state_ff;
  logic [CW-1:0]  ch_ff;              // Executing channel.
  logic [CW-1:0]  last_ff;            // Last channel picked, for rotation.
  logic [31:0]    wsrc_ff;            // Live source address.
  logic [31:0]    wdst_ff;            // Live destination address.
  logic [31:0]    wrd_ff;             // Bytes left to read, shown on readback.
  logic [31:0]    wwr_ff;             // Bytes left to write.
  logic [63:0]    buf_ff;             // Gathered bytes awaiting a write.
  logic [3:0]     cnt_ff;             // Valid bytes in the buffer.
  logic           pre_ff;             // A channel is suspended.
  logic [CW-1:0]  pch_ff;             // Suspended channel index.
  logic [31:0]    psrc_ff;            // Suspended source address.
  logic [31:0]    pdst_ff;            // Suspended destination address.
  logic [31:0]    prd_ff;             // Suspended read count.
  logic [31:0]    pwr_ff;             // Suspended write count.

  logic [NCH-1:0] pend;
  logic [NCH-1:0] busy;
  logic [CW:0]    pick;
  logic [CW:0]    hi;
  logic [2:0]     sb;
  logic [2:0]     db;
  logic           final_it;
  logic           preempt;
  logic           wr_acc;
  logic           rd_acc;

  // Running and suspended channels must not be picked again.
  always_comb begin
    busy = '0;
    if (state_ff != dcs_pkg::ST_IDLE) busy[ch_ff] = 1'b1;
    if (pre_ff) busy[pch_ff] = 1'b1;
  end

  // A request counts as software start, or as an enabled peripheral line.
  assign pend = ({NCH{1'b0}} | (hwre_ff & i_dma_req)) & ~busy;  // [R18]
  logic [NCH-1:0] swp;
  always_comb begin
    for (int i = 0; i < NCH; i++) swp[i] = csr_ff[i][`DCS_B_START];
  end
  assign pick = arbitrate(pend | (swp & ~busy), rr_ff, last_ff);
  assign hi   = arbitrate(pend | (swp & ~busy), 1'b0, last_ff);
  assign sb   = size_bytes(csr_ff[ch_ff][`DCS_B_SSIZE +: 2]);
  assign db   = size_bytes(csr_ff[ch_ff][`DCS_B_DSIZE +: 2]);
  assign final_it = (citer_ff[ch_ff] <= 16'h1);

  // Preempt at a drained unit boundary, fixed mode only, one level deep.
  assign preempt = !rr_ff && csr_ff[ch_ff][`DCS_B_PREEMPT] && !pre_ff && hi[CW]
                   && (hi[CW-1:0] > ch_ff);               // [R14]

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  // ****************************************************************
  // Memory-side request, held until acknowledged.
  // ****************************************************************
  assign o_mem_req   = (state_ff == dcs_pkg::ST_READ) || (state_ff == dcs_pkg::ST_WRITE);
  assign o_mem_we    = (state_ff == dcs_pkg::ST_WRITE);
  assign o_mem_addr  = o_mem_we ? wdst_ff : wsrc_ff;
  assign o_mem_size  = o_mem_we ? csr_ff[ch_ff][`DCS_B_DSIZE +: 2] : csr_ff[ch_ff][`DCS_B_SSIZE +: 2];
  assign o_mem_wdata = buf_ff[31:0];

  // ****************************************************************
  // Sequencer: selection, minor loop, preemption and resume.
  // ****************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= dcs_pkg::ST_IDLE;
      ch_ff    <= '0;
      last_ff  <= '0;
      wsrc_ff  <= '0;
      wdst_ff  <= '0;
      wrd_ff   <= '0;
      wwr_ff   <= '0;
      buf_ff   <= '0;
      cnt_ff   <= '0;
      pre_ff   <= 1'b0;
      pch_ff   <= '0;
      psrc_ff  <= '0;
      pdst_ff  <= '0;
      prd_ff   <= '0;
      pwr_ff   <= '0;
    end else begin
      unique case (state_ff)
        dcs_pkg::ST_IDLE: begin
          // One pick starts exactly one major iteration.
          if (pick[CW]) begin                             // [R1]
            ch_ff    <= pick[CW-1:0];
            last_ff  <= pick[CW-1:0];
            state_ff <= dcs_pkg::ST_LOAD;
          end
        end
        dcs_pkg::ST_LOAD: begin
          // Descriptor copied into the working set after the status update.
          wsrc_ff  <= sa_ff[ch_ff];                       // [R2]
          wdst_ff  <= da_ff[ch_ff];
          wrd_ff   <= nb_ff[ch_ff];
          wwr_ff   <= nb_ff[ch_ff];
          buf_ff   <= '0;
          cnt_ff   <= '0;
          state_ff <= (nb_ff[ch_ff] == 32'h0) ? dcs_pkg::ST_WBACK : dcs_pkg::ST_READ;
        end
        dcs_pkg::ST_READ: begin
          if (i_mem_ack) begin
            // Source units are packed little-endian behind the bytes already held.
            buf_ff  <= buf_ff | ({32'h0, i_mem_rdata & ~(32'hffff_ffff << {sb, 3'h0})} << {cnt_ff, 3'h0});  // [R20]
            cnt_ff  <= cnt_ff + 4'(sb);
            wsrc_ff <= mod_next(wsrc_ff, soff_ff[ch_ff], csr_ff[ch_ff][`DCS_B_SMOD +: 5]);
            wrd_ff  <= wrd_ff - 32'(sb);                  // [R12]
            if ((cnt_ff + 4'(sb) >= 4'(db)) || (wrd_ff <= 32'(sb))) state_ff <= dcs_pkg::ST_WRITE;
          end
        end
        dcs_pkg::ST_WRITE: begin
          if (i_mem_ack) begin
            buf_ff  <= buf_ff >> {db, 3'h0};
            cnt_ff  <= (cnt_ff > 4'(db)) ? cnt_ff - 4'(db) : 4'h0;
            wdst_ff <= mod_next(wdst_ff, doff_ff[ch_ff], csr_ff[ch_ff][`DCS_B_DMOD +: 5]);  // [R20]
            wwr_ff  <= (wwr_ff > 32'(db)) ? wwr_ff - 32'(db) : 32'h0;
            if (wwr_ff <= 32'(db)) begin
              state_ff <= dcs_pkg::ST_WBACK;
            end else if (cnt_ff >= 4'(2 * db)) begin
              state_ff <= dcs_pkg::ST_WRITE;
            end else if (preempt && cnt_ff == 4'(db)) begin
              // Park the running channel; its active bit is left alone.
              pre_ff   <= 1'b1;                           // [R16]
              pch_ff   <= ch_ff;
              psrc_ff  <= wsrc_ff;
              pdst_ff  <= mod_next(wdst_ff, doff_ff[ch_ff], csr_ff[ch_ff][`DCS_B_DMOD +: 5]);
              prd_ff   <= wrd_ff;
              pwr_ff   <= wwr_ff - 32'(db);
              ch_ff    <= hi[CW-1:0];
              state_ff <= dcs_pkg::ST_LOAD;
            end else begin
              state_ff <= dcs_pkg::ST_READ;
            end
          end
        end
        dcs_pkg::ST_WBACK: begin
          // After the preempting iteration the suspended channel carries on.
          if (pre_ff) begin                               // [R17]
            pre_ff   <= 1'b0;
            ch_ff    <= pch_ff;
            wsrc_ff  <= psrc_ff;
            wdst_ff  <= pdst_ff;
            wrd_ff   <= prd_ff;
            wwr_ff   <= pwr_ff;
            buf_ff   <= '0;
            cnt_ff   <= '0;
            state_ff <= dcs_pkg::ST_READ;
          end else begin
            state_ff <= dcs_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Acknowledge pulses in the cycle after selection from idle, for peripheral-driven requests only.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dma_ack <= '0;
    end else begin
      o_dma_ack <= '0;
      if (state_ff == dcs_pkg::ST_IDLE && pick[CW] && !csr_ff[pick[CW-1:0]][`DCS_B_START]) begin
        o_dma_ack[pick[CW-1:0]] <= 1'b1;                  // [R23]
      end
    end
  end

  // ****************************************************************
  // Descriptor storage: software writes, engine updates take priority.
  // ****************************************************************
  logic          ch_hit;
  logic [CW-1:0] ch_sel;
  logic [2:0]    ch_word;
  logic [11:0]   ch_rel;
  assign ch_rel  = paddr - `DCS_OFS_CH_BASE;
  assign ch_hit  = (paddr >= `DCS_OFS_CH_BASE) && (ch_rel < 12'(NCH << `DCS_CH_STRIDE_LG2));
  assign ch_sel  = ch_rel[`DCS_CH_STRIDE_LG2 +: CW];
  assign ch_word = ch_rel[4:2];

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        sa_ff[i] <= '0; da_ff[i] <= '0; nb_ff[i] <= '0; soff_ff[i] <= '0; doff_ff[i] <= '0;
        slast_ff[i] <= '0; dlast_ff[i] <= '0; citer_ff[i] <= '0; biter_ff[i] <= '0; csr_ff[i] <= '0;
      end
    end else begin
      if (wr_acc && ch_hit) begin
        unique case (ch_word)
          `DCS_W_SADDR:  sa_ff[ch_sel] <= pwdata;
          `DCS_W_DADDR:  da_ff[ch_sel] <= pwdata;
          `DCS_W_NBYTES: nb_ff[ch_sel] <= pwdata;
          `DCS_W_OFFS:   {doff_ff[ch_sel], soff_ff[ch_sel]} <= pwdata;
          `DCS_W_SLAST:  slast_ff[ch_sel] <= pwdata;
          `DCS_W_DLAST:  dlast_ff[ch_sel] <= pwdata;
          `DCS_W_ITER:   {biter_ff[ch_sel], citer_ff[ch_sel]} <= pwdata;
          `DCS_W_CSR: begin
            // Active stays under engine control; done can only be cleared here.
            csr_ff[ch_sel] <= (pwdata & ~32'h0000_00c0) | (csr_ff[ch_sel] & 32'h0000_0040)
                              | (csr_ff[ch_sel] & pwdata & 32'h0000_0080);
          end
        endcase
      end
      if (state_ff == dcs_pkg::ST_IDLE && pick[CW]) begin
        // Start and done clear and active sets on selection for either activation.
        csr_ff[pick[CW-1:0]][`DCS_B_START]  <= 1'b0;      // [R9] [R2] [R7]
        csr_ff[pick[CW-1:0]][`DCS_B_DONE]   <= 1'b0;
        csr_ff[pick[CW-1:0]][`DCS_B_ACTIVE] <= 1'b1;
      end
      if (state_ff == dcs_pkg::ST_WRITE && i_mem_ack && wwr_ff > 32'(db) && cnt_ff < 4'(2 * db)
          && preempt && cnt_ff == 4'(db)) begin
        csr_ff[hi[CW-1:0]][`DCS_B_START]  <= 1'b0;        // [R9]
        csr_ff[hi[CW-1:0]][`DCS_B_DONE]   <= 1'b0;
        csr_ff[hi[CW-1:0]][`DCS_B_ACTIVE] <= 1'b1;
      end
      if (state_ff == dcs_pkg::ST_WBACK) begin
        csr_ff[ch_ff][`DCS_B_ACTIVE] <= 1'b0;             // [R7]
        if (!final_it) begin
          sa_ff[ch_ff]    <= wsrc_ff;                     // [R3]
          da_ff[ch_ff]    <= wdst_ff;
          citer_ff[ch_ff] <= citer_ff[ch_ff] - 16'h1;
        end else begin
          sa_ff[ch_ff]    <= wsrc_ff + slast_ff[ch_ff];   // [R4]
          da_ff[ch_ff]    <= wdst_ff + dlast_ff[ch_ff];
          citer_ff[ch_ff] <= biter_ff[ch_ff];
          csr_ff[ch_ff][`DCS_B_DONE] <= 1'b1;             // [R10]
        end
      end
    end
  end

  // ****************************************************************
  // Global registers; hardware sets win over software clears.
  // ****************************************************************
  logic done_evt;
  assign done_evt = (state_ff == dcs_pkg::ST_WBACK) && final_it;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rr_ff   <= 1'b0;
      hwre_ff <= '0;
      irqf_ff <= '0;
    end else begin
      if (wr_acc && paddr == `DCS_OFS_CTRL) rr_ff <= pwdata[`DCS_B_CTRL_RR];
      if (wr_acc && paddr == `DCS_OFS_HWRE) hwre_ff <= pwdata[NCH-1:0];
      if (wr_acc && paddr == `DCS_OFS_IRQF) irqf_ff <= irqf_ff & ~pwdata[NCH-1:0];
      if (done_evt && csr_ff[ch_ff][`DCS_B_DREQ]) hwre_ff[ch_ff] <= 1'b0;        // [R22]
      if (done_evt && csr_ff[ch_ff][`DCS_B_INTMAJ]) irqf_ff[ch_ff] <= 1'b1;      // [R21] [R4]
    end
  end
  assign o_channel_irq_flags = irqf_ff;

  // ****************************************************************
  // APB read path, loaded in the setup cycle and answered in access.
  // ****************************************************************
  logic [31:0] rd_val;
  logic        rd_bad;
  logic        live;
  // Live values belong to the channel whose working set is loaded, never the handshake lines.
  assign live = ch_hit && (ch_sel == ch_ff) && (state_ff inside {dcs_pkg::ST_READ, dcs_pkg::ST_WRITE});

  always_comb begin
    rd_val = 32'h0;
    rd_bad = 1'b0;
    if (paddr == `DCS_OFS_CTRL) rd_val = {29'h0, rr_ff, 2'h0};
    else if (paddr == `DCS_OFS_HWRE) rd_val = 32'(hwre_ff);
    else if (paddr == `DCS_OFS_IRQF) rd_val = 32'(irqf_ff);
    else if (ch_hit) begin
      unique case (ch_word)
        `DCS_W_SADDR:  rd_val = live ? wsrc_ff : sa_ff[ch_sel];   // [R11]
        `DCS_W_DADDR:  rd_val = live ? wdst_ff : da_ff[ch_sel];
        `DCS_W_NBYTES: rd_val = live ? wrd_ff : nb_ff[ch_sel];    // [R12]
        `DCS_W_OFFS:   rd_val = {doff_ff[ch_sel], soff_ff[ch_sel]}; // [R13]
        `DCS_W_SLAST:  rd_val = slast_ff[ch_sel];
        `DCS_W_DLAST:  rd_val = dlast_ff[ch_sel];
        `DCS_W_ITER:   rd_val = {biter_ff[ch_sel], citer_ff[ch_sel]}; // [R19]
        `DCS_W_CSR:    rd_val = csr_ff[ch_sel];                   // [R8]
      endcase
    end else rd_bad = 1'b1;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= rd_acc ? rd_val : 32'h0;
      pslverr <= rd_bad;
    end
  end
  assign pready = 1'b1;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  sequence s_sel;
    state_ff == dcs_pkg::ST_IDLE && pick[CW];
  endsequence
  sequence s_load;
    state_ff == dcs_pkg::ST_LOAD;
  endsequence

  AST_SEL_THEN_LOAD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R2]
    s_sel |=> s_load ##1 (wrd_ff == nb_ff[ch_ff])) else $error("Selection did not load descriptor.");
  AST_START_CLEARS: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R9]
    s_sel |=> !csr_ff[ch_ff][`DCS_B_START] && csr_ff[ch_ff][`DCS_B_ACTIVE]) else $error("Start not cleared.");
  AST_NONFINAL: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R3]
    (state_ff == dcs_pkg::ST_WBACK && !final_it) |=> citer_ff[$past(ch_ff)] == $past(citer_ff[ch_ff]) - 16'h1
    && !csr_ff[$past(ch_ff)][`DCS_B_DONE]) else $error("Non-final writeback wrong.");
  AST_FINAL: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R4]
    done_evt |=> csr_ff[$past(ch_ff)][`DCS_B_DONE] && citer_ff[$past(ch_ff)] == biter_ff[$past(ch_ff)])
    else $error("Final writeback wrong.");
  AST_IRQ_GATED: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R21]
    (done_evt && !csr_ff[ch_ff][`DCS_B_INTMAJ] && !irqf_ff[ch_ff]) |=> !irqf_ff[$past(ch_ff)])
    else $error("Flag set without enable.");
  AST_DREQ: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R22]
    (done_evt && csr_ff[ch_ff][`DCS_B_DREQ]) |=> !hwre_ff[$past(ch_ff)]) else $error("Enable not cleared.");
  AST_NO_PREEMPT_RR: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R14]
    (rr_ff && !pre_ff) |=> !pre_ff) else $error("Preemption under rotation.");
  AST_PREEMPT_ACTIVE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R16]
    pre_ff |-> csr_ff[pch_ff][`DCS_B_ACTIVE]) else $error("Suspended channel lost active.");
  AST_ACK_PULSE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R23]
    |o_dma_ack |=> !(|o_dma_ack) ##0 (state_ff != dcs_pkg::ST_IDLE)) else $error("Acknowledge not a pulse.");
  AST_RD_DEC: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R12]
    (state_ff == dcs_pkg::ST_READ && i_mem_ack) |=> wrd_ff == $past(wrd_ff) - 32'($past(sb)))
    else $error("Byte count did not fall.");
endmodule // dcs_channel_sequencer

/* File: dcs_mem_model.sv */
`timescale 1ns/100ps
// Bus memory: answers each held unit after i_lat idle cycles, so stalls can be forced.
module dcs_mem_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_lat,
  output logic             o_ack,
  output logic      [31:0] o_rdata,
  output logic      [31:0] o_waddr,
  output logic      [31:0] o_wdata
);
  logic [3:0] wait_ff; // Cycles the current unit has waited.
  // Read data equals the address, so packing shows; outside an answer the bus toggles.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {wait_ff, o_ack, o_rdata, o_waddr, o_wdata} <= '0;
    end else if (o_ack || !i_req) begin
      o_ack   <= 1'b0;
      wait_ff <= 4'h0;
      o_rdata <= ~o_rdata;
    end else if (wait_ff >= i_lat) begin
      o_ack   <= 1'b1;
      o_rdata <= i_addr;
      o_waddr <= i_we ? i_addr : o_waddr;
      o_wdata <= i_we ? i_wdata : o_wdata;
    end else begin
      wait_ff <= wait_ff + 4'h1;
      o_rdata <= ~o_rdata;
    end
  end
endmodule // dcs_mem_model

/* File: test_dcs_channel_sequencer.sv */
`timescale 1ns/100ps
`include "dcs_params.svh"
module test_dcs_channel_sequencer;
  logic        i_ref_clk = 0, i_rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, mreq, mwe, mack;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q, waddr, wdata, rdata, maddr, mwdata;
  logic [3:0]  dreq = '0, ack, irq, lat = '0;
  logic [1:0]  msize;
  logic [31:0] td [8];
  int          fail_count = 0, num_checks = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  dcs_channel_sequencer u_dcs_channel_sequencer (.i_ref_clk, .i_rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .i_dma_req(dreq), .o_dma_ack(ack), .o_channel_irq_flags(irq),
    .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_addr(maddr), .o_mem_size(msize), .o_mem_wdata(mwdata),
    .i_mem_ack(mack), .i_mem_rdata(rdata));
  dcs_mem_model u_dcs_mem_model (.i_ref_clk, .i_rst_n, .i_req(mreq), .i_we(mwe), .i_addr(maddr),
    .i_wdata(mwdata), .i_lat(lat), .o_ack(mack), .o_rdata(rdata), .o_waddr(waddr), .o_wdata(wdata));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One APB transfer; request held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge i_ref_clk);
      if (pready === 1'b1) break;
    end
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      fail_count++;
      end_of_test();
    end
    @(posedge i_ref_clk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(q & m, e);
  endtask
  // Polls a register; progress is only visible through register contents.
  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    for (n = 0; n < 400; n++) begin
      apb(1'b0, a, '0);
      if ((q & m) === e) break;
    end
    if (n == 400) begin
      fail_count++;
      end_of_test();
    end
  endtask
  function automatic logic [11:0] ca(input int ch, input int w);
    return `DCS_OFS_CH_BASE + 12'((ch << `DCS_CH_STRIDE_LG2) + w * 4);
  endfunction
  task automatic load(input int ch);
    for (int w = 0; w < 8; w++) apb(1'b1, ca(ch, w), td[w]);
  endtask
  // Peripheral keeps its request until acknowledged, then drops it at once.
  task automatic hwreq(input int ch);
    int n;
    dreq[ch] <= 1'b1;
    for (n = 0; n < 50 && ack[ch] !== 1'b1; n++) @(posedge i_ref_clk);
    dreq[ch] <= 1'b0;
    if (n == 50) begin
      fail_count++;
      end_of_test();
    end
  endtask
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    rc(`DCS_OFS_IRQF, '1, '0);
    apb(1'b0, 12'h0fc, '0);
    chk({31'h0, err}, 32'h1);
    td = '{32'h1000, 32'h2000, 32'h10, 32'h0004_0001, 32'hffff_ffe0, 32'hffff_ffe0, 32'h0002_0002, 32'h0000_080a};
    load(1);
    dreq[1] <= 1'b1;
    rc(ca(1, 7), 32'hc1, '0);
    rc(ca(1, 6), '1, 32'h0002_0002);
    apb(1'b1, `DCS_OFS_HWRE, 32'h2);
    hwreq(1);
    poll(ca(1, 6), 32'hffff, 32'h1);
    rc(ca(1, 0), '1, 32'h1010);
    rc(ca(1, 1), '1, 32'h2010);
    rc(ca(1, 7), 32'hc1, '0);
    rc(`DCS_OFS_IRQF, '1, '0);
    chk(waddr, 32'h200c);
    chk(wdata, 32'h0f0e_0d0c);
    lat <= 4'hf;
    hwreq(1);
    poll(ca(1, 2), '1, 32'hc);
    poll(ca(1, 7), 32'h80, 32'h80);
    rc(ca(1, 0), '1, 32'h1000);
    rc(ca(1, 1), '1, 32'h2000);
    rc(ca(1, 6), '1, 32'h0002_0002);
    rc(`DCS_OFS_IRQF, '1, 32'h2);
    chk({28'h0, irq}, 32'h2);
    rc(`DCS_OFS_HWRE, '1, '0);
    chk(wdata, 32'h1f1e_1d1c);
    apb(1'b1, `DCS_OFS_IRQF, 32'h2);
    rc(`DCS_OFS_IRQF, '1, '0);
    lat <= 4'h0;
    td = '{32'h1234_5670, 32'h3000, 32'h14, 32'h0004_0004, 0, 0, 32'h0001_0001, 32'h0004_0a00};
    load(0);
    apb(1'b1, ca(0, 7), 32'h0004_0a01);
    poll(ca(0, 7), 32'hc1, 32'h80);
    rc(ca(0, 0), '1, 32'h1234_5674);
    rc(ca(0, 1), '1, 32'h3014);
    rc(ca(0, 3), '1, 32'h0004_0004);
    rc(`DCS_OFS_IRQF, '1, '0);
    chk(wdata, 32'h1234_5670);
    lat <= 4'hf;
    apb(1'b1, ca(0, 7), 32'h0004_0a11);
    apb(1'b1, ca(1, 7), 32'h0000_080b);
    poll(ca(1, 7), 32'h41, 32'h40);
    rc(ca(0, 7), 32'h41, 32'h40);
    poll(ca(0, 7), 32'hc1, 32'h80);
    rc(ca(1, 6), '1, 32'h0002_0001);
    rc(ca(0, 0), '1, 32'h1234_5678);
    rc(ca(0, 1), '1, 32'h3028);
    chk(wdata, 32'h1234_5674);
    apb(1'b1, `DCS_OFS_CTRL, 32'h4);
    rc(`DCS_OFS_CTRL, '1, 32'h4);
    end_of_test();
  end
endmodule // test_dcs_channel_sequencer
